/* File: logic/adc_conversion_control.sv */
// Conversion control for the general_purpose_converter: APB registers, scheduling, threshold and shutdown
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Software enables software conversions before starting
// [RULE2] Convert channel chosen by software select field
// [RULE3] Power on demand unless always-on bit set
// [RULE4] Software done interrupt gated by its mask
// [RULE5] Slot 0 start bit launches one conversion
// [RULE6] Completion sets software done flag, raises interrupt
// [RULE7] Result split: high nibble, low byte
// [RULE8] Periodic slot 0 converts its selected channel
// [RULE9] Rate field sets periodic conversion interval
// [RULE10] Twelve-bit threshold in high and low registers
// [RULE11] Polarity bit picks above or below trip
// [RULE12] Shutdown enable makes trip request shutdown
// [RULE13] Periodic conversions run only when enabled
// [RULE14] Threshold crossing sets periodic flag, interrupt
// [RULE15] Periodic results kept in separate registers
// [RULE16] Shutdown after delay unless flag cleared first
// [RULE17] Second slot mirrors slot 0 completely
// [RULE18] Flags stay until cleared; masked still record
module adc_conversion_control #(
  parameter int unsigned TICK_CYCLES = adc_conv_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output adc_conv_pkg::conv_req_t convReq,
  input wire adc_conv_pkg::conv_rsp_t convRsp,
  output logic [1:0] currentSource,
  output logic irq,
  output logic shutdownReq
);
  localparam int unsigned NS = adc_conv_pkg::NSLOT;
  localparam int unsigned CW = adc_conv_pkg::CHAN_W;
  localparam int unsigned RW = adc_conv_pkg::RSLT_W;

  logic rstMeta_r;
  logic rstSync_r;
  logic rstn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rstn = rstSync_r;

  // Register storage
  logic swEnable_r;
  logic [CW-1:0] swChan_r [NS];
  logic [CW-1:0] autoChan_r [NS];
  logic alwaysOn_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [7:0] rateField_r;
  logic [NS-1:0] autoEn_r;
  logic [NS-1:0] tripSd_r;
  logic [RW-1:0] limit_r [NS];
  logic [NS-1:0] limitPol_r;
  logic [RW-1:0] swRes_r [NS];
  logic [RW-1:0] autoRes_r [NS];
  logic [7:0] swoffDly_r;

  // APB decode
  logic setupPh;
  logic wrEn;
  logic rdEn;
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pready && pwrite;
  assign rdEn = psel && penable && pready && !pwrite;

  logic [31:0] rdData;
  logic rdHit;
  always_comb begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    case (paddr)
      adc_conv_pkg::ADDR_SW_SEL: begin
        rdData[CW-1:0] = swChan_r[0];
        rdData[adc_conv_pkg::SW_CHAN1_POS +: CW] = swChan_r[1];
        rdData[adc_conv_pkg::SW_EN_POS] = swEnable_r;
      end
      adc_conv_pkg::ADDR_CTRL_ONE: rdData[2:0] = {currentSource, alwaysOn_r};
      adc_conv_pkg::ADDR_IRQ_STATUS: rdData[3:0] = status_r;
      adc_conv_pkg::ADDR_IRQ_MASK: rdData[3:0] = mask_r;
      adc_conv_pkg::ADDR_AUTO_SEL: begin
        rdData[CW-1:0] = autoChan_r[0];
        rdData[adc_conv_pkg::SW_CHAN1_POS +: CW] = autoChan_r[1];
      end
      adc_conv_pkg::ADDR_AUTO_CTRL: begin
        rdData[7:0] = rateField_r;
        rdData[adc_conv_pkg::AUTO_EN0_POS +: NS] = autoEn_r;
        rdData[adc_conv_pkg::AUTO_SD0_POS +: NS] = tripSd_r;
      end
      adc_conv_pkg::ADDR_SWITCH_OFF_DELAY: rdData[7:0] = swoffDly_r;
      default: begin
        rdHit = 1'b0;
        for (int s = 0; s < NS; s++) begin
          // Threshold high register carries the polarity bit above the nibble
          if (paddr == adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s)) begin
            rdData[7:0] = {limitPol_r[s], 3'b000, limit_r[s][11:8]}; // RULE11
            rdHit = 1'b1;
          end
          if (paddr == adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s + 4)) begin
            rdData[7:0] = limit_r[s][7:0]; // RULE10
            rdHit = 1'b1;
          end
          if (paddr == adc_conv_pkg::ADDR_SW_RES_BASE + 8'(8 * s)) begin
            rdData[3:0] = swRes_r[s][11:8]; // RULE7
            rdHit = 1'b1;
          end
          if (paddr == adc_conv_pkg::ADDR_SW_RES_BASE + 8'(8 * s + 4)) begin
            rdData[7:0] = swRes_r[s][7:0]; // RULE7
            rdHit = 1'b1;
          end
          if (paddr == adc_conv_pkg::ADDR_AUTO_RES_BASE + 8'(8 * s)) begin
            rdData[3:0] = autoRes_r[s][11:8]; // RULE15
            rdHit = 1'b1;
          end
          if (paddr == adc_conv_pkg::ADDR_AUTO_RES_BASE + 8'(8 * s + 4)) begin
            rdData[7:0] = autoRes_r[s][7:0]; // RULE15
            rdHit = 1'b1;
          end
        end
      end
    endcase
  end

  // Answer registered in the setup cycle, so every access has zero wait states
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPh;
      prdata <= (setupPh && !pwrite) ? rdData : 32'h0000_0000;
      pslverr <= setupPh && !rdHit;
    end
  end

  logic wrOk;
  assign wrOk = wrEn && !pslverr;

  // Configuration writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swEnable_r <= 1'b0;
      alwaysOn_r <= 1'b0;
      currentSource <= 2'b00;
      mask_r <= adc_conv_pkg::MASK_RST;
      rateField_r <= 8'h00;
      autoEn_r <= '0;
      tripSd_r <= '0;
      limitPol_r <= '0;
      swoffDly_r <= adc_conv_pkg::SWOFF_RST;
      for (int s = 0; s < NS; s++) begin
        swChan_r[s] <= '0;
        autoChan_r[s] <= '0;
        limit_r[s] <= '0;
      end
    end else if (wrOk) begin
      case (paddr)
        adc_conv_pkg::ADDR_SW_SEL: begin
          swChan_r[0] <= pwdata[CW-1:0]; // RULE2
          swChan_r[1] <= pwdata[adc_conv_pkg::SW_CHAN1_POS +: CW]; // RULE17
          swEnable_r <= pwdata[adc_conv_pkg::SW_EN_POS];
        end
        adc_conv_pkg::ADDR_CTRL_ONE: begin
          alwaysOn_r <= pwdata[0]; // RULE3
          currentSource <= pwdata[2:1]; // RULE2
        end
        adc_conv_pkg::ADDR_IRQ_MASK: mask_r <= pwdata[3:0];
        adc_conv_pkg::ADDR_AUTO_SEL: begin
          autoChan_r[0] <= pwdata[CW-1:0]; // RULE8
          autoChan_r[1] <= pwdata[adc_conv_pkg::SW_CHAN1_POS +: CW]; // RULE17
        end
        adc_conv_pkg::ADDR_AUTO_CTRL: begin
          rateField_r <= pwdata[7:0]; // RULE9
          autoEn_r <= pwdata[adc_conv_pkg::AUTO_EN0_POS +: NS]; // RULE13
          tripSd_r <= pwdata[adc_conv_pkg::AUTO_SD0_POS +: NS]; // RULE12
        end
        adc_conv_pkg::ADDR_SWITCH_OFF_DELAY: swoffDly_r <= pwdata[7:0];
        default: begin
          for (int s = 0; s < NS; s++) begin
            if (paddr == adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s)) begin
              limit_r[s][11:8] <= pwdata[3:0]; // RULE10
              limitPol_r[s] <= pwdata[adc_conv_pkg::POL_POS]; // RULE11
            end
            if (paddr == adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s + 4)) begin
              limit_r[s][7:0] <= pwdata[7:0]; // RULE10
            end
          end
        end
      endcase
    end
  end

  // Software start strobes; ignored while software conversions are disabled
  logic [NS-1:0] swStartWr;
  assign swStartWr = (wrOk && paddr == adc_conv_pkg::ADDR_SW_SEL && swEnable_r) ?
    pwdata[adc_conv_pkg::SW_START0_POS +: NS] : '0; // RULE1 RULE5

  // Periodic rate timer: interval is (rate + 1) base ticks
  logic [$clog2(TICK_CYCLES + 1)-1:0] tickCnt_r;
  logic [7:0] rateCnt_r;
  logic tick;
  logic autoFire;
  assign tick = (32'(tickCnt_r) == TICK_CYCLES - 1);
  assign autoFire = tick && (rateCnt_r == rateField_r);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_r <= '0;
      rateCnt_r <= 8'h00;
    end else if (autoEn_r == '0) begin
      tickCnt_r <= '0;
      rateCnt_r <= 8'h00;
    end else begin
      tickCnt_r <= tick ? '0 : tickCnt_r + 1'b1;
      if (tick) begin
        rateCnt_r <= autoFire ? 8'h00 : rateCnt_r + 8'h01; // RULE9
      end
    end
  end
  // Whole converter answer passes two stages; data is already steady when done rises, so all bits agree
  adc_conv_pkg::conv_rsp_t rspMeta_r;
  adc_conv_pkg::conv_rsp_t rspSync_r;
  logic doneDly_r;
  logic doneRise;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rspMeta_r <= '0;
      rspSync_r <= '0;
      doneDly_r <= 1'b0;
    end else begin
      rspMeta_r <= convRsp;
      rspSync_r <= rspMeta_r;
      doneDly_r <= rspSync_r.done;
    end
  end
  assign doneRise = rspSync_r.done && !doneDly_r;
  // Pending requests: [1:0] software slots, [3:2] periodic slots, lowest index first
  logic [3:0] pend_r;
  logic [1:0] curIdx_r;
  adc_conv_pkg::conv_state_t state_r;
  logic [$clog2(adc_conv_pkg::PWRUP_CYC + 1)-1:0] pwrCnt_r;
  logic [1:0] pickIdx;
  logic [CW-1:0] pickChan;
  logic convEnd;

  always_comb begin
    pickIdx = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (pend_r[i]) begin
        pickIdx = 2'(i);
      end
    end
  end
  assign pickChan = pickIdx[1] ? autoChan_r[pickIdx[0]] : swChan_r[pickIdx[0]]; // RULE2 RULE8
  assign convEnd = (state_r == adc_conv_pkg::ST_WAIT) && doneRise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 4'h0;
    end else begin
      // A request taken while its slot waits merges into it; one taken as the slot is picked stays pending
      pend_r <= (pend_r & ~((state_r == adc_conv_pkg::ST_IDLE && pend_r != 4'h0) ?
        (4'h1 << pickIdx) : 4'h0)) | {autoEn_r & {NS{autoFire}}, swStartWr}; // RULE13 RULE17
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= adc_conv_pkg::ST_IDLE;
      curIdx_r <= 2'd0;
      pwrCnt_r <= '0;
      convReq <= '0;
    end else begin
      convReq.start <= 1'b0;
      case (state_r)
        adc_conv_pkg::ST_IDLE: begin
          convReq.powerOn <= alwaysOn_r; // RULE3
          if (pend_r != 4'h0) begin
            curIdx_r <= pickIdx;
            convReq.channel <= pickChan;
            convReq.powerOn <= 1'b1;
            pwrCnt_r <= '0;
            // Already powered: skip the settle wait to cut latency
            state_r <= alwaysOn_r ? adc_conv_pkg::ST_START : adc_conv_pkg::ST_PWRUP; // RULE3
          end
        end
        adc_conv_pkg::ST_PWRUP: begin
          pwrCnt_r <= pwrCnt_r + 1'b1;
          if (32'(pwrCnt_r) == adc_conv_pkg::PWRUP_CYC - 1) begin
            state_r <= adc_conv_pkg::ST_START;
          end
        end
        adc_conv_pkg::ST_START: begin
          convReq.start <= 1'b1; // RULE5
          state_r <= adc_conv_pkg::ST_WAIT;
        end
        adc_conv_pkg::ST_WAIT: begin
          if (doneRise) begin
            convReq.powerOn <= alwaysOn_r; // RULE3
            state_r <= adc_conv_pkg::ST_IDLE;
          end
        end
        default: state_r <= adc_conv_pkg::ST_IDLE;
      endcase
    end
  end

  // Result capture and threshold compare per slot; data is stable once done is seen
  logic [3:0] evSet;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : gSlot
      logic isSw;
      logic isAuto;
      logic trip;
      assign isSw = convEnd && curIdx_r == 2'(g);
      assign isAuto = convEnd && curIdx_r == 2'(g + 2);
      assign trip = limitPol_r[g] ? (rspSync_r.data > limit_r[g]) : (rspSync_r.data < limit_r[g]); // RULE11
      assign evSet[adc_conv_pkg::ST_SW0 + g] = isSw; // RULE6
      assign evSet[adc_conv_pkg::ST_AUTO0 + g] = isAuto && trip; // RULE14
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          swRes_r[g] <= '0;
          autoRes_r[g] <= '0;
        end else begin
          if (isSw) begin
            swRes_r[g] <= rspSync_r.data; // RULE7
          end
          if (isAuto) begin
            autoRes_r[g] <= rspSync_r.data; // RULE15
          end
        end
      end
    end
  endgenerate

  // Sticky status; a read clears only the bits it returned, so an event after the setup cycle is kept
  logic statusRd;
  assign statusRd = rdEn && paddr == adc_conv_pkg::ADDR_IRQ_STATUS;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 4'h0;
    end else begin
      status_r <= (statusRd ? (status_r & ~prdata[3:0]) : status_r) | evSet; // RULE18 RULE6 RULE14
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & ~mask_r); // RULE4 RULE18
    end
  end
  // Switch-off countdown in base ticks; clearing the flag cancels it
  logic sdPend;
  logic [$clog2(TICK_CYCLES + 1)-1:0] sdTick_r;
  logic [7:0] sdCnt_r;
  assign sdPend = |(status_r[adc_conv_pkg::ST_AUTO0 +: NS] & tripSd_r); // RULE12
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdTick_r <= '0;
      sdCnt_r <= 8'h00;
      shutdownReq <= 1'b0;
    end else if (!sdPend) begin
      sdTick_r <= '0;
      sdCnt_r <= 8'h00; // RULE16
    end else if (32'(sdTick_r) == TICK_CYCLES - 1) begin
      sdTick_r <= '0;
      if (sdCnt_r + 8'h01 >= swoffDly_r) begin
        shutdownReq <= 1'b1; // RULE16
      end else begin
        sdCnt_r <= sdCnt_r + 8'h01;
      end
    end else begin
      sdTick_r <= sdTick_r + 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: logic/adc_conv_pkg.sv */
// Shared constants, register map and types for the converter control block
package adc_conv_pkg;
  localparam int unsigned CLK_MHZ = 25;
  // Converter power-up settle time, least time, rounded up to cycles
  localparam int unsigned PWRUP_NS = 2000;
  localparam int unsigned PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  // Base tick of the periodic rate and the switch-off delay
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  localparam int unsigned RSLT_W = 12;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned NSLOT = 2;
  localparam int unsigned FULL_SCALE = 4096;

  localparam logic [7:0] ADDR_SW_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_AUTO_SEL = 8'h10;
  localparam logic [7:0] ADDR_AUTO_CTRL = 8'h14;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h18;
  localparam logic [7:0] ADDR_SW_RES_BASE = 8'h28;
  localparam logic [7:0] ADDR_AUTO_RES_BASE = 8'h38;
  localparam logic [7:0] ADDR_SWITCH_OFF_DELAY = 8'h48;

  // sw_request_select_reg fields
  localparam int unsigned SW_CHAN1_POS = 4;
  localparam int unsigned SW_EN_POS = 8;
  localparam int unsigned SW_START0_POS = 9;
  // periodic_control_reg fields
  localparam int unsigned AUTO_EN0_POS = 8;
  localparam int unsigned AUTO_SD0_POS = 10;
  // limit high register polarity bit
  localparam int unsigned POL_POS = 7;
  // Status and mask bits, mask and switch-off delay reset values
  localparam int unsigned ST_SW0 = 0;
  localparam int unsigned ST_AUTO0 = 2;
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [7:0] SWOFF_RST = 8'h01;

  typedef struct packed {
    logic start;
    logic powerOn;
    logic [CHAN_W-1:0] channel;
  } conv_req_t;

  typedef struct packed {
    logic done;
    logic [RSLT_W-1:0] data;
  } conv_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PWRUP = 2'b01,
    ST_START = 2'b10,
    ST_WAIT = 2'b11
  } conv_state_t;
endpackage

/* File: sim/adc_conversion_control_props.sv */
// Port-level checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_props #(
  parameter int unsigned TICK_CYCLES = adc_conv_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_conv_pkg::conv_req_t convReq,
  input wire adc_conv_pkg::conv_rsp_t convRsp,
  input wire logic [1:0] currentSource,
  input wire logic irq,
  input wire logic shutdownReq
);
  logic clr;
  // Only a status read or a mask write may take the interrupt down
  assign clr = psel && penable && pready &&
    (pwrite ? paddr == adc_conv_pkg::ADDR_IRQ_MASK : paddr == adc_conv_pkg::ADDR_IRQ_STATUS);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_ready_next;
    psel && !penable |=> pready && penable;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready missing after setup");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside access");
  property p_start_pulse;
    convReq.start |=> !convReq.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start wider than a pulse");
  property p_start_power;
    convReq.start |-> convReq.powerOn;
  endproperty
  a_start_power: assert property (p_start_power) else $error("start while unpowered");
  property p_power_wait;
    $rose(convReq.powerOn) |-> !convReq.start [*8];
  endproperty
  a_power_wait: assert property (p_power_wait) else $error("start before power settled");
  property p_chan_hold;
    convReq.start |=> $stable(convReq.channel) [*4];
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved in conversion");
  property p_sd_sticky;
    shutdownReq |=> shutdownReq;
  endproperty
  a_sd_sticky: assert property (p_sd_sticky) else $error("shutdown request dropped");
  property p_irq_fall;
    $fell(irq) |-> $past(clr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
endmodule
bind adc_conversion_control adc_conversion_control_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .convReq(convReq),
  .convRsp(convRsp), .currentSource(currentSource), .irq(irq), .shutdownReq(shutdownReq));
`default_nettype wire

/* File: sim/adc_conversion_control_test.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_test;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, shutdownReq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [1:0] currentSource;
  adc_conv_pkg::conv_req_t convReq;
  adc_conv_pkg::conv_rsp_t convRsp;
  logic [11:0] cv, lim;
  logic [11:0] sres [2];
  logic [2:0] lastChan, ch;
  int n_errors, checks_done, nStart;

  adc_conversion_control #(.TICK_CYCLES(10)) u_adc_conversion_control (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convReq(convReq), .convRsp(convRsp), .currentSource(currentSource), .irq(irq),
    .shutdownReq(shutdownReq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Converter stand-in: data valid only around done, inverted afterwards
  initial begin
    convRsp = '0;
    forever begin
      @(posedge clk);
      if (convReq.start === 1'b1) begin
        lastChan = convReq.channel;
        nStart++;
        repeat ($urandom_range(2, 9)) @(posedge clk);
        convRsp <= {1'b1, cv};
        repeat (6) @(posedge clk);
        convRsp <= {1'b0, ~cv};
      end
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task waitirq;
    for (int i = 0; i < 150 && irq !== 1'b1; i++) @(posedge clk);
  endtask

  // Software request on one slot; returns well after the conversion landed
  task swc(input int s);
    int n;
    n = nStart;
    apb(1'b1, adc_conv_pkg::ADDR_SW_SEL, 32'h100 | (32'(ch) << (4 * s)));
    apb(1'b1, adc_conv_pkg::ADDR_SW_SEL, 32'h100 | (32'(ch) << (4 * s)) | (32'h200 << s));
    for (int i = 0; i < 100 && nStart == n; i++) @(posedge clk);
    chk(nStart, n + 1);
    repeat (25) @(posedge clk);
  endtask

  task final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end

  initial begin
    void'($urandom(32'h5605ab3d));
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cv = 12'h0;
    ch = 3'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a <= 'h48; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk(q, a == 'h0c ? 32'hf : a == 'h48 ? 32'h1 : 32'h0);
    end
    apb(1'b1, 8'h4c, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h4c, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    for (int s = 0; s < 2; s++) begin
      d = $urandom;
      apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s), d);
      apb(1'b0, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s), 32'h0);
      chk(q, d & 32'h8f);
      apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s + 4), d);
      apb(1'b0, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * s + 4), 32'h0);
      chk(q, d & 32'hff);
    end
    // Start without the enable, periodic rate set but no slot enabled
    apb(1'b1, adc_conv_pkg::ADDR_AUTO_CTRL, 32'h1);
    apb(1'b1, adc_conv_pkg::ADDR_SW_SEL, 32'h200);
    repeat (80) @(posedge clk);
    chk(nStart, 0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      apb(1'b1, adc_conv_pkg::ADDR_CTRL_ONE, {29'h0, d[2:1], i[1]});
      apb(1'b1, adc_conv_pkg::ADDR_IRQ_MASK, i == 3 ? 32'hf : 32'h0);
      chk(currentSource, d[2:1]);
      cv = 12'($urandom);
      ch = 3'($urandom);
      sres[i % 2] = cv;
      swc(i % 2);
      chk(lastChan, ch);
      chk(irq, i != 3);
      apb(1'b0, adc_conv_pkg::ADDR_SW_RES_BASE + 8'(8 * (i % 2)), 32'h0);
      chk(q, cv[11:8]);
      apb(1'b0, adc_conv_pkg::ADDR_SW_RES_BASE + 8'(8 * (i % 2) + 4), 32'h0);
      chk(q, cv[7:0]);
      apb(1'b0, adc_conv_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(q, 32'h1 << (i % 2));
      apb(1'b0, adc_conv_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(q, 32'h0);
    end
    // Equal value never trips; one step past the limit does, per polarity
    for (int i = 0; i < 8; i++) begin
      lim = 12'($urandom_range(1, 4094));
      cv = i[2] ? (i[1] ? lim + 12'h1 : lim - 12'h1) : lim;
      ch = 3'($urandom);
      apb(1'b1, adc_conv_pkg::ADDR_AUTO_SEL, 32'(ch) << (4 * i[0]));
      apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * i[0]), {24'h0, i[1], 3'h0, lim[11:8]});
      apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE + 8'(8 * i[0] + 4), {24'h0, lim[7:0]});
      apb(1'b1, adc_conv_pkg::ADDR_IRQ_MASK, 32'hf ^ (32'h4 << i[0]));
      apb(1'b1, adc_conv_pkg::ADDR_AUTO_CTRL, 32'h1 | (32'h100 << i[0]));
      waitirq;
      chk(irq, i[2]);
      chk(lastChan, ch);
      apb(1'b1, adc_conv_pkg::ADDR_AUTO_CTRL, 32'h0);
      repeat (30) @(posedge clk);
      apb(1'b0, adc_conv_pkg::ADDR_AUTO_RES_BASE + 8'(8 * i[0] + 4), 32'h0);
      chk(q, cv[7:0]);
      apb(1'b0, adc_conv_pkg::ADDR_SW_RES_BASE + 8'(8 * i[0] + 4), 32'h0);
      chk(q, sres[i[0]][7:0]);
      apb(1'b0, adc_conv_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(q, i[2] ? 32'h4 << i[0] : 32'h0);
    end
    // Delay long enough that in-flight conversions settle before the clear
    cv = 12'hfff;
    apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE, 32'h80);
    apb(1'b1, adc_conv_pkg::ADDR_LIMIT_BASE + 8'h4, 32'h0);
    apb(1'b1, adc_conv_pkg::ADDR_SWITCH_OFF_DELAY, 32'h8);
    apb(1'b1, adc_conv_pkg::ADDR_IRQ_MASK, 32'hb);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, adc_conv_pkg::ADDR_AUTO_CTRL, 32'h501);
      waitirq;
      apb(1'b1, adc_conv_pkg::ADDR_AUTO_CTRL, 32'h400);
      repeat (30) @(posedge clk);
      if (k == 0) apb(1'b0, adc_conv_pkg::ADDR_IRQ_STATUS, 32'h0);
      repeat (150) @(posedge clk);
      chk(shutdownReq, k);
    end
    final_report;
  end
endmodule
`default_nettype wire
